/* crt_map_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts for the crt output block
// Assumes: word-indexed register port, 8-bit data
// Notes: included by bare name
`ifndef CRT_MAP_REGS_SVH
`define CRT_MAP_REGS_SVH
`define ADDR_INPUT_STATUS    8'hc2
`define ADDR_DISPLAY_SELECT  8'h19
`define ADDR_HOST_BUS_CTRL   8'h31
`define ADDR_MAP_ACCESS_CTRL 8'h30
`define ADDR_MAP_ADDR        8'h33
`define ADDR_MAP_DATA        8'h34
`define ADDR_SYNC_CTRL       8'h40
`define ADDR_DAC_STATUS      8'h41
`define BIT_SENSE            4
`define BIT_PANEL_EN         4
`define BIT_CRT_EN           5
`define BIT_IO16_EN          0
`define BIT_HSYNC_NEG        0
`define BIT_VSYNC_NEG        1
`define BIT_SYNC_LOCK        2
`define MAP_UNLOCK_KEY       8'h30
`define RST_DISPLAY_SELECT   8'h00
`define RST_HOST_BUS_CTRL    8'h01
`define RST_SYNC_CTRL        8'h03
`define MAP_GAP_CYCLES       3'h4
`endif

/* crt_map_pkg.sv */
// Purpose: types shared by the crt output block
// Assumes: nothing
// Notes: constants live in crt_map_regs.svh
package crt_map_pkg;
	typedef enum logic [2:0]
	{
		map_idle_s   = 3'b001,
		map_unlock_s = 3'b010,
		map_wait_s   = 3'b100
	} map_state_t;
	typedef enum logic [1:0]
	{
		lines_reserved_t = 2'b00,
		lines_350_t      = 2'b01,
		lines_400_t      = 2'b10,
		lines_480_t      = 2'b11
	} frame_lines_t;
endpackage

/* gray_map_ram.sv */
// Purpose: 64 x 6 gray mapping memory, one pixel port and one cpu port
// Assumes: single clock, registered read data on both ports
// Notes: cpu write wins no priority over pixel read; ports are independent
`timescale 1ns/1ps
module gray_map_ram #(
	parameter int DEPTH = 64,
	parameter int AW    = 6,
	parameter int DW    = 6
)(
	// clock
	input  wire logic          clk_sys,
	// pixel port
	input  wire logic [AW-1:0] pix_addr,
	output      logic [DW-1:0] pix_data,
	// cpu port
	input  wire logic [AW-1:0] cpu_addr,
	input  wire logic          cpu_we,
	input  wire logic [DW-1:0] cpu_wdata,
	output      logic [DW-1:0] cpu_rdata
);
	logic [DW-1:0] mem [DEPTH];
	always_ff @(posedge clk_sys)
	begin
		if (cpu_we)
			mem[cpu_addr] <= cpu_wdata;
	end
	always_ff @(posedge clk_sys)
	begin
		pix_data  <= mem[pix_addr];
		cpu_rdata <= mem[cpu_addr];
	end
endmodule // gray_map_ram

/* crt_map_ctrl.sv */
// Purpose: crt/panel selection, sync polarity, monitor sense readout, dac gating and gray mapping
// Assumes: sense comparators come from another clock domain; blanking arrives already on clk_sys
// Notes: register data 8 bits, read data one cycle after the strobe
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "crt_map_regs.svh"
module crt_map_ctrl
	import crt_map_pkg::*;
#(
	parameter int CLK_HZ   = 10000000,
	parameter int SENSE_NS = 300
)(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output      logic [7:0] reg_rdata,
	// chip state
	input  wire logic       chip_enable,
	input  wire logic       power_down,
	input  wire logic       retrace,
	// dac comparators, asynchronous
	input  wire logic [2:0] cmp_below,
	// pixel path
	input  wire logic [5:0] weight_in,
	output      logic [5:0] dither_out,
	output      logic [3:0] plasma_out,
	// display outputs
	output      logic       crt_enable,
	output      logic       panel_enable,
	output      logic       simul_display,
	output      logic       dac_on,
	output      logic       hsync_neg,
	output      logic       vsync_neg,
	output      logic [1:0] frame_lines
);
	localparam int SENSE_CYC_RAW = (SENSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SENSE_CYC     = (SENSE_CYC_RAW < 1) ? 1 : SENSE_CYC_RAW;

	logic [7:0] disp_sel_q;
	logic [7:0] host_bus_q;
	logic [7:0] sync_ctrl_q;
	logic [5:0] map_addr_q;
	logic [2:0] cmp_s1_q;
	logic [2:0] cmp_s2_q;
	logic [2:0] cmp_s3_q;
	logic       sense_q;
	logic [7:0] rdata_q;
	logic       map_rd_q;
	logic [2:0] gap_q;
	logic [7:0] stable_q;
	logic       map_err_q;
	map_state_t state_q;
	logic [5:0] map_rdata;
	logic       map_allowed;
	logic       map_data_hit;
	logic       map_go;

	assign panel_enable  = disp_sel_q[`BIT_PANEL_EN];
	assign crt_enable    = disp_sel_q[`BIT_CRT_EN];
	assign simul_display = panel_enable & crt_enable;
	assign dac_on        = crt_enable & chip_enable & ~power_down & ~retrace;
	assign map_allowed   = panel_enable & ~power_down;
	assign map_data_hit  = (reg_addr == `ADDR_MAP_DATA) & (reg_wr | reg_rd);
	assign map_go        = map_data_hit & map_allowed & (state_q == map_unlock_s);

	// display select and host bus control
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			disp_sel_q <= `RST_DISPLAY_SELECT;
			host_bus_q <= `RST_HOST_BUS_CTRL;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `ADDR_DISPLAY_SELECT)
				disp_sel_q <= reg_wdata;
			if (reg_addr == `ADDR_HOST_BUS_CTRL)
				host_bus_q <= reg_wdata;
		end
	end

	// sync polarity; lock bit freezes the bits until reset, any unlock write is refused
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			sync_ctrl_q <= `RST_SYNC_CTRL;
		else if (reg_wr && reg_addr == `ADDR_SYNC_CTRL && !sync_ctrl_q[`BIT_SYNC_LOCK] && !simul_display)
			sync_ctrl_q <= {5'h00, reg_wdata[2:0]};
	end

	// simultaneous display overrides whatever software chose
	assign hsync_neg = simul_display | sync_ctrl_q[`BIT_HSYNC_NEG];
	assign vsync_neg = simul_display | sync_ctrl_q[`BIT_VSYNC_NEG];
	assign frame_lines = {hsync_neg, vsync_neg};

	// comparators arrive from the analog side: three flops, change on agreement
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cmp_s1_q <= 3'h0;
			cmp_s2_q <= 3'h0;
			cmp_s3_q <= 3'h0;
		end
		else
		begin
			cmp_s1_q <= cmp_below;
			cmp_s2_q <= cmp_s1_q;
			cmp_s3_q <= cmp_s2_q;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			sense_q <= 1'b0;
		else if (cmp_s2_q == cmp_s3_q)
			sense_q <= &cmp_s3_q;
	end

	// counts how long the dac has stayed on; software still owns the settle wait
	always_ff @(posedge clk_sys)
	begin
		if (rst || !dac_on)
			stable_q <= 8'h00;
		else if (stable_q != 8'hff)
			stable_q <= stable_q + 8'h01;
	end

	// mapping access sequencer: unlock, one data access, then a gap
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_q <= map_idle_s;
			gap_q   <= 3'h0;
		end
		else
		begin
			unique case (state_q)
				map_idle_s:
				begin
					if (reg_wr && reg_addr == `ADDR_MAP_ACCESS_CTRL && reg_wdata == `MAP_UNLOCK_KEY)
						state_q <= map_unlock_s;
				end
				map_unlock_s:
				begin
					if (map_go)
					begin
						state_q <= map_wait_s;
						gap_q   <= `MAP_GAP_CYCLES;
					end
				end
				map_wait_s:
				begin
					// hardware spacing guards the memory if software skimps on the wait
					if (gap_q == 3'h1)
						state_q <= map_idle_s;
					gap_q <= gap_q - 3'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			map_addr_q <= 6'h00;
		else if (reg_wr && reg_addr == `ADDR_MAP_ADDR)
			map_addr_q <= reg_wdata[5:0];
	end

	// refused data accesses are remembered; io16 left on also counts as a fault
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			map_err_q <= 1'b0;
		else if (map_data_hit && (!map_go || host_bus_q[`BIT_IO16_EN]))
			map_err_q <= 1'b1;
		else if (reg_rd && reg_addr == `ADDR_DAC_STATUS)
			map_err_q <= 1'b0;
	end

	gray_map_ram #(
		.DEPTH (64),
		.AW    (6),
		.DW    (6)
	) u_ram (
		.clk_sys   (clk_sys),
		.pix_addr  (weight_in),
		.pix_data  (dither_out),
		.cpu_addr  (map_addr_q),
		.cpu_we    (map_go & reg_wr),
		.cpu_wdata (reg_wdata[5:0]),
		.cpu_rdata (map_rdata)
	);

	assign plasma_out = dither_out[3:0];

	// read data: memory answer is already registered, so pick it in the next cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			map_rd_q <= 1'b0;
		else
			map_rd_q <= map_go & reg_rd;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdata_q <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`ADDR_INPUT_STATUS:    rdata_q <= {3'h0, sense_q, 4'h0};
				`ADDR_DISPLAY_SELECT:  rdata_q <= disp_sel_q;
				`ADDR_HOST_BUS_CTRL:   rdata_q <= host_bus_q;
				`ADDR_MAP_ADDR:        rdata_q <= {2'h0, map_addr_q};
				`ADDR_SYNC_CTRL:       rdata_q <= {5'h00, sync_ctrl_q[2], vsync_neg, hsync_neg};
				`ADDR_DAC_STATUS:      rdata_q <= {map_err_q, (stable_q >= 8'(SENSE_CYC)), 3'h0, state_q};
				default:               rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end

	assign reg_rdata = map_rd_q ? {2'h0, map_rdata} : rdata_q;

	property p_dac_off;
		@(posedge clk_sys) disable iff (rst)
		(retrace || power_down || !crt_enable || !chip_enable) |-> !dac_on;
	endproperty
	a_dac_off: assert property (p_dac_off) else $error("dac driven while off");

	property p_dac_crt;
		@(posedge clk_sys) disable iff (rst)
		dac_on |-> crt_enable;
	endproperty
	a_dac_crt: assert property (p_dac_crt) else $error("dac on without crt");

	property p_simul_480;
		@(posedge clk_sys) disable iff (rst)
		simul_display |-> frame_lines == lines_480_t;
	endproperty
	a_simul_480: assert property (p_simul_480) else $error("simultaneous sync not 480");

	property p_lock_hold;
		@(posedge clk_sys) disable iff (rst)
		sync_ctrl_q[`BIT_SYNC_LOCK] |=> $stable(sync_ctrl_q);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked sync changed");

	property p_crt_write;
		@(posedge clk_sys) disable iff (rst)
		reg_wr && reg_addr == `ADDR_DISPLAY_SELECT |=> crt_enable == $past(reg_wdata[`BIT_CRT_EN]);
	endproperty
	a_crt_write: assert property (p_crt_write) else $error("crt enable not written");

	property p_sense_all;
		@(posedge clk_sys) disable iff (rst)
		$rose(sense_q) |-> $past(&cmp_s3_q);
	endproperty
	a_sense_all: assert property (p_sense_all) else $error("sense without all comparators");

	property p_status_read;
		@(posedge clk_sys) disable iff (rst)
		reg_rd && reg_addr == `ADDR_INPUT_STATUS |=> reg_rdata[`BIT_SENSE] == $past(sense_q);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status bit 4 wrong");

	property p_map_gate;
		@(posedge clk_sys) disable iff (rst)
		map_go |-> panel_enable && !power_down;
	endproperty
	a_map_gate: assert property (p_map_gate) else $error("mapping access while barred");

	property p_one_access;
		@(posedge clk_sys) disable iff (rst)
		map_go |=> !map_go [*4];
	endproperty
	a_one_access: assert property (p_one_access) else $error("mapping accesses too close");

	property p_plasma;
		@(posedge clk_sys) disable iff (rst)
		plasma_out === dither_out[3:0];
	endproperty
	a_plasma: assert property (p_plasma) else $error("plasma bits differ");
endmodule // crt_map_ctrl

/* crt_monitor_model.sv */
// Purpose: behavioural crt monitor as seen by the dac sense comparators
// Assumes: bench chooses which colour terminations are attached
// Notes: an unpowered dac sits below reference on every channel
`timescale 1ns/1ps
module crt_monitor_model (
	// dac drive state
	input  wire logic       dac_on,
	// attached terminations {b,g,r}
	input  wire logic [2:0] term,
	// comparator outputs, high = below reference
	output      logic [2:0] cmp_below
);
	// zero-current outputs read as below reference, so sense only means something while driven
	assign cmp_below = dac_on ? term : 3'h7;
endmodule // crt_monitor_model

/* crt_output_and_gray_mapping_test.sv */
// Purpose: self-checking bench for the crt output and gray mapping block
// Assumes: register port with read data one cycle after the strobe
// Notes: sync lock clears only by reset, so the lock test runs last
`timescale 1ns/1ps
`include "crt_map_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module crt_output_and_gray_mapping_test;
	import crt_map_pkg::*;
	logic       clk_sys, rst, reg_wr, reg_rd, chip_enable, power_down, retrace;
	logic       crt_enable, panel_enable, simul_display, dac_on, hsync_neg, vsync_neg;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [5:0] weight_in, dither_out;
	logic [3:0] plasma_out;
	logic [2:0] cmp_below, term;
	logic [1:0] frame_lines;
	int         error_cnt, num_checks, cyc;
	frame_lines_t lines_tab [4] = '{lines_reserved_t, lines_400_t, lines_350_t, lines_480_t};

	crt_map_ctrl i_crt_map_ctrl (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_enable(chip_enable),
		.power_down(power_down), .retrace(retrace), .cmp_below(cmp_below), .weight_in(weight_in),
		.dither_out(dither_out), .plasma_out(plasma_out), .crt_enable(crt_enable),
		.panel_enable(panel_enable), .simul_display(simul_display), .dac_on(dac_on),
		.hsync_neg(hsync_neg), .vsync_neg(vsync_neg), .frame_lines(frame_lines));
	crt_monitor_model i_crt_monitor_model (.dac_on(dac_on), .term(term), .cmp_below(cmp_below));

	function automatic logic [5:0] ent(input int k);
		return 6'(k) ^ 6'h2a;
	endfunction

	// the write strobe stays up between back-to-back writes; idle drops it, rd drops its own strobe after one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_rd <= 1'h0;
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_wr <= 1'h0;
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		@(negedge clk_sys);
		d = reg_rdata;
		@(posedge clk_sys);
	endtask

	task automatic idle();
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		@(posedge clk_sys);
	endtask

	task automatic map(input logic [5:0] idx, input logic is_wr, input logic [7:0] d, output logic [7:0] q);
		wr(`ADDR_MAP_ACCESS_CTRL, `MAP_UNLOCK_KEY);
		wr(`ADDR_MAP_ADDR, {2'h0, idx});
		rd(`ADDR_DISPLAY_SELECT, q);
		if (is_wr)
			wr(`ADDR_MAP_DATA, d);
		else
			rd(`ADDR_MAP_DATA, q);
		idle();
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ceiling well above the roughly 1600 cycles the sequence needs
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("[FAIL] %0t timeout", $time);
			close_out();
		end
	end

	initial
	begin
		int i;
		logic [7:0] v;
		rst = 1'h1;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		chip_enable = 1'h1;
		power_down = 1'h0;
		retrace = 1'h0;
		term = 3'h0;
		weight_in = 6'h00;
		repeat (4) @(posedge clk_sys);
		rst <= 1'h0;
		idle();
		rd(`ADDR_DISPLAY_SELECT, v);
		`CHK(v, `RST_DISPLAY_SELECT)
		rd(`ADDR_HOST_BUS_CTRL, v);
		`CHK(v, `RST_HOST_BUS_CTRL)
		rd(`ADDR_SYNC_CTRL, v);
		`CHK(v, `RST_SYNC_CTRL)
		for (i = 0; i < 4; i++)
		begin
			wr(`ADDR_SYNC_CTRL, 8'(i));
			idle();
			`CHK({hsync_neg, vsync_neg}, {i[0], i[1]})
			`CHK(frame_lines, lines_tab[i])
		end
		// every enable, power-down and retrace mix, crt path on and off
		for (i = 0; i < 16; i++)
		begin
			wr(`ADDR_DISPLAY_SELECT, {2'h0, i[3], 5'h00});
			chip_enable <= i[0];
			power_down <= i[1];
			retrace <= i[2];
			idle();
			@(negedge clk_sys);
			`CHK(crt_enable, i[3])
			`CHK(dac_on, i[3] & i[0] & ~i[1] & ~i[2])
			@(posedge clk_sys);
		end
		chip_enable <= 1'h1;
		power_down <= 1'h0;
		retrace <= 1'h0;
		wr(`ADDR_DISPLAY_SELECT, 8'h30);
		idle();
		`CHK(simul_display, 1'h1)
		`CHK(panel_enable, 1'h1)
		wr(`ADDR_SYNC_CTRL, 8'h00);
		idle();
		`CHK(frame_lines, lines_480_t)
		// sense only while driven and out of retrace; wait beyond the settle time
		wr(`ADDR_DISPLAY_SELECT, 8'h20);
		for (i = 5; i < 8; i++)
		begin
			term <= 3'(i);
			idle();
			repeat (8) @(posedge clk_sys);
			rd(`ADDR_INPUT_STATUS, v);
			`CHK(v[`BIT_SENSE], i == 7)
		end
		rd(`ADDR_DAC_STATUS, v);
		`CHK(v[7:6], 2'h1)
		wr(`ADDR_DISPLAY_SELECT, 8'h10);
		wr(`ADDR_HOST_BUS_CTRL, 8'h00);
		for (i = 0; i < 64; i++)
			map(6'(i), 1'h1, {2'h0, ent(i)}, v);
		for (i = 0; i < 64; i++)
		begin
			map(6'(i), 1'h0, 8'h00, v);
			`CHK(v, {2'h0, ent(i)})
			weight_in <= 6'(i);
			@(posedge clk_sys);
			@(negedge clk_sys);
			`CHK(dither_out, ent(i))
			`CHK(plasma_out, ent(i) & 6'h0f)
			@(posedge clk_sys);
		end
		power_down <= 1'h1;
		map(6'h3f, 1'h1, 8'h00, v);
		rd(`ADDR_DAC_STATUS, v);
		`CHK(v[7], 1'h1)
		power_down <= 1'h0;
		map(6'h3f, 1'h0, 8'h00, v);
		`CHK(v, {2'h0, ent(63)})
		rd(`ADDR_DAC_STATUS, v);
		`CHK(v[7], 1'h0)
		// io16 left on still lets the access through but is flagged
		wr(`ADDR_HOST_BUS_CTRL, 8'h01);
		map(6'h00, 1'h0, 8'h00, v);
		`CHK(v, {2'h0, ent(0)})
		rd(`ADDR_DAC_STATUS, v);
		`CHK(v[7], 1'h1)
		wr(`ADDR_HOST_BUS_CTRL, 8'h00);
		wr(`ADDR_SYNC_CTRL, 8'h05);
		wr(`ADDR_SYNC_CTRL, 8'h02);
		idle();
		`CHK(frame_lines, lines_400_t)
		close_out();
	end
endmodule // crt_output_and_gray_mapping_test
